// ### src/rc_tune_params.svh
// offsets, field positions, reset values and timing counts of the rc tuning and pll clocking block
// Contract
// - setting bit 15 of the tuning register starts hardware self-calibration
// - bit 12 picks the reference: 1 usb start-of-frame, 0 secondary crystal
// - while tuning, compare fast rc against 8 MHz and adjust trim bits 5..0
// - while tuning, software writes to the trim field are ignored
// - bit 11 flags drift beyond 0.2 percent and may raise the tune interrupt
// - bit 9 flags deviation beyond 1.5 percent and may raise the interrupt
// - bits 10 and 8 choose interrupt on presence or absence of each condition
// - pll fed from fast rc when current source is 001, primary when 011
// - current source field loads from the initial source configuration
// - otherwise pll source bit picks fast rc at 0, primary at 1
// - vco runs at 96 MHz, usb clock is a free running divide by 2
// - usb mode divides vco by 3 then postscaler 1, 2, 4 or 8
// - prescale codes 0111..0001 divide by 12, 8, 6, 5, 4, 3, 2
// - outside usb mode multiply 4x, 6x or 8x with no prescaler
`ifndef RC_TUNE_PARAMS_SVH
`define RC_TUNE_PARAMS_SVH

`define OFS_OSC_TUNING 8'h00
`define OFS_PLL_CFG 8'h04
`define OFS_CLK_STATUS 8'h08

`define BIT_TUNE_EN 15
`define BIT_TUNE_SRC 12
`define BIT_LOCK_STAT 11
`define BIT_LOCK_POL 10
`define BIT_RANGE_STAT 9
`define BIT_RANGE_POL 8
`define TRIM_MSB 5

`define CFG_COSC_LSB 0
`define CFG_PLL_SOURCE_CONFIG_BIT 4
`define CFG_POST_LSB 8
`define CFG_PRE_LSB 12
`define CFG_MULT_LSB 16
`define CFG_USB_BIT 20

`define RST_TUNING 32'h0000_0000
`define RST_PLL_CFG 32'h0000_0000

`define FRC_NOMINAL_KHZ 8000
`define SOF_PERIOD_US 1000
`define SECONDARY_CRYSTAL_OSC_EDGES 256
`define SECONDARY_CRYSTAL_OSC_HZ 32768
`define SOF_EXPECT (`FRC_NOMINAL_KHZ * `SOF_PERIOD_US / 1000)
`define SECONDARY_CRYSTAL_OSC_EXPECT (`FRC_NOMINAL_KHZ * 1000 * `SECONDARY_CRYSTAL_OSC_EDGES / `SECONDARY_CRYSTAL_OSC_HZ)
`define LOCK_PPT 2
`define RANGE_PPT 15

`endif

// ### src/rc_tune_pkg.sv
// types shared by the rc tuning and pll clocking block
`default_nettype none
package rc_tune_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    MULT_4X,
    MULT_6X,
    MULT_8X,
    MULT_RSVD
  } pll_mult_t;

  typedef enum {
    TUNE_IDLE,
    TUNE_PRIME,
    TUNE_MEASURE
  } tune_state_t;
endpackage
`default_nettype wire

// ### src/rc_self_tune_and_pll_clocking.sv
// fast rc self tuning, pll source selection and clock tree dividers behind an apb slave
`default_nettype none
`include "rc_tune_params.svh"
module rc_self_tune_and_pll_clocking (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire rc_tune_pkg::apb_req_t apb_req,
  output rc_tune_pkg::apb_rsp_t apb_rsp,
  input wire logic [2:0] initial_osc_config,
  input wire logic frc_tick,
  input wire logic usb_sof_pulse,
  input wire logic secondary_crystal_osc_tick,
  input wire logic pll_in_tick,
  input wire logic vco_tick,
  output logic [5:0] rc_trim_field,
  output logic self_tune_irq_flag,
  output logic pll_from_primary,
  output logic pll_ref_tick,
  output logic usb_clk_tick,
  output logic sys_clk_tick,
  output logic [1:0] pll_mult_sel
);
  import rc_tune_pkg::*;

  logic rst_meta_r;
  logic rst_sync_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // prescale code to divisor, zero means pass through
  function automatic logic [3:0] pre_div(input logic [3:0] code);
    case (code)
      4'h7: pre_div = 4'hc;
      4'h6: pre_div = 4'h8;
      4'h5: pre_div = 4'h6;
      4'h4: pre_div = 4'h5;
      4'h3: pre_div = 4'h4;
      4'h2: pre_div = 4'h3;
      4'h1: pre_div = 4'h2;
      default: pre_div = 4'h1;
    endcase
  endfunction

  // register decode, shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    case (a)
      `OFS_OSC_TUNING: reg_sel = 2'd1;
      `OFS_PLL_CFG: reg_sel = 2'd2;
      `OFS_CLK_STATUS: reg_sel = 2'd3;
      default: reg_sel = 2'd0;
    endcase
  endfunction

  logic tune_en_r;
  logic tune_src_r;
  logic lock_pol_r;
  logic range_pol_r;
  logic tune_lock_status;
  logic tune_out_of_range_status;
  logic [5:0] trim_r;
  logic [2:0] current_osc_select;
  logic pll_source_config;
  logic [1:0] sysclk_postscaler;
  logic [3:0] pll_prescale_code;
  logic [1:0] mult_r;
  logic usb_mode_r;
  logic cosc_loaded_r;
  logic [31:0] prdata_r;

  logic wr_en;
  logic setup_rd;
  logic [1:0] sel;
  assign sel = reg_sel(apb_req.paddr);
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

  // zero wait states; unmapped addresses answer with an error
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & (sel == 2'd0);
  assign apb_rsp.prdata = prdata_r;

  logic [31:0] tune_word;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;
  always_comb begin
    tune_word = 32'h0000_0000;
    tune_word[`BIT_TUNE_EN] = tune_en_r;
    tune_word[`BIT_TUNE_SRC] = tune_src_r;
    tune_word[`BIT_LOCK_STAT] = tune_lock_status;
    tune_word[`BIT_LOCK_POL] = lock_pol_r;
    tune_word[`BIT_RANGE_STAT] = tune_out_of_range_status;
    tune_word[`BIT_RANGE_POL] = range_pol_r;
    tune_word[`TRIM_MSB:0] = trim_r;
    cfg_word = 32'h0000_0000;
    cfg_word[`CFG_COSC_LSB +: 3] = current_osc_select;
    cfg_word[`CFG_PLL_SOURCE_CONFIG_BIT] = pll_source_config;
    cfg_word[`CFG_POST_LSB +: 2] = sysclk_postscaler;
    cfg_word[`CFG_PRE_LSB +: 4] = pll_prescale_code;
    cfg_word[`CFG_MULT_LSB +: 2] = mult_r;
    cfg_word[`CFG_USB_BIT] = usb_mode_r;
    stat_word = 32'h0000_0000;
    stat_word[0] = self_tune_irq_flag;
    stat_word[1] = pll_from_primary;
    stat_word[7:4] = pre_div(pll_prescale_code);
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_rd) begin
      case (sel)
        2'd1: prdata_r <= tune_word;
        2'd2: prdata_r <= cfg_word;
        2'd3: prdata_r <= stat_word;
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // constant, so the async reset branch loads no logic
  localparam logic [31:0] rst_tune = `RST_TUNING;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tune_en_r <= rst_tune[`BIT_TUNE_EN];
      tune_src_r <= rst_tune[`BIT_TUNE_SRC];
      lock_pol_r <= rst_tune[`BIT_LOCK_POL];
      range_pol_r <= rst_tune[`BIT_RANGE_POL];
    end else if (wr_en && sel == 2'd1) begin
      tune_en_r <= apb_req.pwdata[`BIT_TUNE_EN];
      tune_src_r <= apb_req.pwdata[`BIT_TUNE_SRC];
      lock_pol_r <= apb_req.pwdata[`BIT_LOCK_POL];
      range_pol_r <= apb_req.pwdata[`BIT_RANGE_POL];
    end
  end

  // constant, so the async reset branch loads no logic
  localparam logic [31:0] rst_cfg = `RST_PLL_CFG;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pll_source_config <= rst_cfg[`CFG_PLL_SOURCE_CONFIG_BIT];
      sysclk_postscaler <= rst_cfg[`CFG_POST_LSB +: 2];
      pll_prescale_code <= rst_cfg[`CFG_PRE_LSB +: 4];
      mult_r <= rst_cfg[`CFG_MULT_LSB +: 2];
      usb_mode_r <= rst_cfg[`CFG_USB_BIT];
    end else if (wr_en && sel == 2'd2) begin
      pll_source_config <= apb_req.pwdata[`CFG_PLL_SOURCE_CONFIG_BIT];
      sysclk_postscaler <= apb_req.pwdata[`CFG_POST_LSB +: 2];
      pll_prescale_code <= apb_req.pwdata[`CFG_PRE_LSB +: 4];
      mult_r <= apb_req.pwdata[`CFG_MULT_LSB +: 2];
      usb_mode_r <= apb_req.pwdata[`CFG_USB_BIT];
    end
  end

  // strap caught on the first clock after reset release, not by the reset itself
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cosc_loaded_r <= 1'b0;
      current_osc_select <= 3'h0;
    end else if (!cosc_loaded_r) begin
      cosc_loaded_r <= 1'b1;
      current_osc_select <= initial_osc_config;
    end else if (wr_en && sel == 2'd2) begin
      current_osc_select <= apb_req.pwdata[`CFG_COSC_LSB +: 3];
    end
  end

  // measurement: count fast rc ticks over one reference window
  tune_state_t state_r;
  logic [16:0] frc_cnt_r;
  logic [7:0] secondary_crystal_osc_cnt_r;
  logic ref_evt;
  logic [16:0] expect_cnt;
  logic [16:0] lock_tol;
  logic [16:0] range_tol;
  localparam logic [16:0] SOF_N = 17'(`SOF_EXPECT);
  localparam logic [16:0] SECONDARY_CRYSTAL_OSC_N = 17'(`SECONDARY_CRYSTAL_OSC_EXPECT);

  always_comb begin
    ref_evt = tune_src_r ? usb_sof_pulse : (secondary_crystal_osc_tick && secondary_crystal_osc_cnt_r == 8'hff);
    expect_cnt = tune_src_r ? SOF_N : SECONDARY_CRYSTAL_OSC_N;
    lock_tol = 17'((`LOCK_PPT * 32'(expect_cnt)) / 1000);
    range_tol = 17'((`RANGE_PPT * 32'(expect_cnt)) / 1000);
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      secondary_crystal_osc_cnt_r <= 8'h00;
    end else if (!tune_en_r || tune_src_r) begin
      secondary_crystal_osc_cnt_r <= 8'h00;
    end else if (secondary_crystal_osc_tick) begin
      secondary_crystal_osc_cnt_r <= secondary_crystal_osc_cnt_r + 8'h01;
    end
  end

  logic window_done;
  assign window_done = (state_r == TUNE_MEASURE) && ref_evt;

  // first window after enable starts on a reference edge, partial counts are discarded
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= TUNE_IDLE;
    end else begin
      case (state_r)
        TUNE_IDLE: if (tune_en_r) state_r <= TUNE_PRIME;
        TUNE_PRIME: begin
          if (!tune_en_r) state_r <= TUNE_IDLE;
          else if (ref_evt) state_r <= TUNE_MEASURE;
        end
        TUNE_MEASURE: if (!tune_en_r) state_r <= TUNE_IDLE;
        default: state_r <= TUNE_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      frc_cnt_r <= 17'h0_0000;
    end else if (ref_evt || state_r != TUNE_MEASURE) begin
      frc_cnt_r <= {16'h0000, frc_tick};
    end else if (frc_tick && frc_cnt_r != 17'h1_ffff) begin
      frc_cnt_r <= frc_cnt_r + 17'h0_0001;
    end
  end

  logic fast;
  logic [16:0] dev;
  always_comb begin
    fast = frc_cnt_r > expect_cnt;
    dev = fast ? frc_cnt_r - expect_cnt : expect_cnt - frc_cnt_r;
  end

  // status holds the last completed window's verdict
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tune_lock_status <= 1'b0;
      tune_out_of_range_status <= 1'b0;
    end else if (!tune_en_r) begin
      tune_lock_status <= 1'b0;
      tune_out_of_range_status <= 1'b0;
    end else if (window_done) begin
      tune_lock_status <= dev > lock_tol;
      tune_out_of_range_status <= dev > range_tol;
    end
  end

  // trim is signed; saturates at the ends rather than wrapping
  logic trim_at_max;
  logic trim_at_min;
  assign trim_at_max = trim_r == 6'h1f;
  assign trim_at_min = trim_r == 6'h20;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trim_r <= rst_tune[`TRIM_MSB:0];
    end else if (tune_en_r) begin
      if (window_done && dev > lock_tol) begin
        if (fast && !trim_at_min) trim_r <= trim_r - 6'h01;
        else if (!fast && !trim_at_max) trim_r <= trim_r + 6'h01;
      end
    end else if (wr_en && sel == 2'd1) begin
      trim_r <= apb_req.pwdata[`TRIM_MSB:0];
    end
  end
  assign rc_trim_field = trim_r;

  // polarity 1 raises on presence of the condition, 0 on its absence
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      self_tune_irq_flag <= 1'b0;
    end else begin
      self_tune_irq_flag <= (state_r == TUNE_MEASURE)
        && ((tune_lock_status == lock_pol_r) || (tune_out_of_range_status == range_pol_r));
    end
  end

  // pll input source
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pll_from_primary <= 1'b0;
    end else begin
      case (current_osc_select)
        3'h1: pll_from_primary <= 1'b0;
        3'h3: pll_from_primary <= 1'b1;
        default: pll_from_primary <= pll_source_config;
      endcase
    end
  end

  // dividers on incoming clock ticks; outputs are one-cycle registered pulses
  logic [3:0] pre_cnt_r;
  logic [3:0] pre_n;
  assign pre_n = usb_mode_r ? pre_div(pll_prescale_code) : 4'h1;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre_cnt_r <= 4'h0;
      pll_ref_tick <= 1'b0;
    end else begin
      pll_ref_tick <= 1'b0;
      if (pll_in_tick) begin
        if (pre_cnt_r + 4'h1 >= pre_n) begin
          pre_cnt_r <= 4'h0;
          pll_ref_tick <= 1'b1;
        end else begin
          pre_cnt_r <= pre_cnt_r + 4'h1;
        end
      end
    end
  end

  // usb branch never gated, so it runs whatever the postscaler says
  logic usb_half_r;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      usb_half_r <= 1'b0;
      usb_clk_tick <= 1'b0;
    end else begin
      usb_clk_tick <= vco_tick & usb_half_r;
      if (vco_tick) usb_half_r <= ~usb_half_r;
    end
  end

  logic [4:0] sys_cnt_r;
  logic [4:0] sys_n;
  always_comb begin
    case (sysclk_postscaler)
      2'd0: sys_n = usb_mode_r ? 5'd3 : 5'd1;
      2'd1: sys_n = usb_mode_r ? 5'd6 : 5'd2;
      2'd2: sys_n = usb_mode_r ? 5'd12 : 5'd4;
      default: sys_n = usb_mode_r ? 5'd24 : 5'd8;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sys_cnt_r <= 5'd0;
      sys_clk_tick <= 1'b0;
    end else begin
      sys_clk_tick <= 1'b0;
      if (vco_tick) begin
        if (sys_cnt_r + 5'd1 >= sys_n) begin
          sys_cnt_r <= 5'd0;
          sys_clk_tick <= 1'b1;
        end else begin
          sys_cnt_r <= sys_cnt_r + 5'd1;
        end
      end
    end
  end

  // reserved multiplier code falls back to 4x
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pll_mult_sel <= MULT_4X;
    end else if (usb_mode_r) begin
      pll_mult_sel <= MULT_4X;
    end else begin
      pll_mult_sel <= (mult_r == MULT_RSVD) ? MULT_4X : mult_r;
    end
  end
endmodule // rc_self_tune_and_pll_clocking
`default_nettype wire

// ### testbench/rc_tune_checker.sv
// assertions on the ports of the rc tuning and pll clocking block
`default_nettype none
module rc_tune_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire rc_tune_pkg::apb_req_t apb_req,
  input wire rc_tune_pkg::apb_rsp_t apb_rsp,
  input wire logic usb_sof_pulse,
  input wire logic secondary_crystal_osc_tick,
  input wire logic pll_in_tick,
  input wire logic vco_tick,
  input wire logic [5:0] rc_trim_field,
  input wire logic self_tune_irq_flag,
  input wire logic pll_ref_tick,
  input wire logic usb_clk_tick,
  input wire logic sys_clk_tick,
  input wire logic [1:0] pll_mult_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic acc, wr, mapped;
  logic [3:0] ev_hist, wr_hist;
  assign acc = apb_req.psel && apb_req.penable;
  assign wr = acc && apb_req.pwrite;
  assign mapped = apb_req.paddr inside {8'h00, 8'h04, 8'h08};
  // short history, so a status lag of a cycle is no false alarm
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_hist <= 4'h0;
      wr_hist <= 4'h0;
    end else begin
      ev_hist <= {ev_hist[2:0], usb_sof_pulse | secondary_crystal_osc_tick};
      wr_hist <= {wr_hist[2:0], wr};
    end
  end
  sequence half_rate_s;
    $past(vco_tick) ##1 !usb_clk_tick;
  endsequence
  pready_now_a: assert property (acc |-> apb_rsp.pready)
    else $error("no ready in access");
  bad_addr_a: assert property (acc && !mapped |-> apb_rsp.pslverr)
    else $error("unmapped access accepted");
  good_addr_a: assert property (acc && mapped |-> !apb_rsp.pslverr)
    else $error("mapped access refused");
  usb_half_a: assert property (usb_clk_tick |-> half_rate_s)
    else $error("usb tick not half rate");
  ref_tick_a: assert property (pll_ref_tick |-> $past(pll_in_tick))
    else $error("ref tick without input");
  sys_tick_a: assert property (sys_clk_tick |-> $past(vco_tick))
    else $error("sys tick without vco");
  trim_cause_a: assert property ($changed(rc_trim_field) |-> |{ev_hist, wr_hist})
    else $error("trim moved unprompted");
  irq_cause_a: assert property ($rose(self_tune_irq_flag) |-> |{ev_hist, wr_hist})
    else $error("irq rose unprompted");
  mult_cause_a: assert property ($changed(pll_mult_sel) |-> |wr_hist)
    else $error("mult moved unprompted");
endmodule // rc_tune_checker
`default_nettype wire

// ### testbench/usb_host_model.sv
// usb host model issuing start-of-frame pulses
`default_nettype none
module usb_host_model (
  input wire logic sys_clk,
  input wire logic en,
  input wire logic [15:0] frame_len,
  output logic sof
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  logic last;
  assign last = cnt_r >= frame_len - 16'h1;
  // a suspended or detached host sends no frames at all
  always_ff @(posedge sys_clk) begin
    if (!en) begin
      cnt_r <= 16'h0;
      sof <= 1'b0;
    end else begin
      cnt_r <= last ? 16'h0 : cnt_r + 16'h1;
      sof <= last;
    end
  end
endmodule // usb_host_model
`default_nettype wire

// ### testbench/rc_self_tune_and_pll_clocking_tb_top.sv
// self-checking bench for the rc tuning and pll clocking block
`default_nettype none
module rc_self_tune_and_pll_clocking_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rc_tune_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic fast_rc_osc = 1'b0, secondary_crystal_osc = 1'b0, pin = 1'b0, vco = 1'b0, host_en = 1'b0, secondary_crystal_osc_en = 1'b0;
  logic sof, irq, from_pri, ref_t, usb_t, sys_t;
  logic [15:0] flen = 16'd7000;
  logic [7:0] sdiv = 8'h0;
  logic [5:0] trim, r;
  logic [1:0] mult;
  logic [31:0] q_exp[$], q_msk[$];
  int bad_count = 0, n_tests = 0, n_sys = 0, n_usb = 0, n_ref = 0, n_secondary_crystal_osc = 0;
  int dv[8] = '{1, 2, 3, 4, 5, 6, 8, 12};
  logic [4:0] src_cfg[4] = '{5'h11, 5'h10, 5'h00, 5'h03};
  logic src_exp[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  always #5 sys_clk = ~sys_clk;
  rc_self_tune_and_pll_clocking rc_self_tune_and_pll_clocking_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .initial_osc_config(3'b011),
    .frc_tick(fast_rc_osc), .usb_sof_pulse(sof), .secondary_crystal_osc_tick(secondary_crystal_osc), .pll_in_tick(pin), .vco_tick(vco),
    .rc_trim_field(trim), .self_tune_irq_flag(irq), .pll_from_primary(from_pri), .pll_ref_tick(ref_t),
    .usb_clk_tick(usb_t), .sys_clk_tick(sys_t), .pll_mult_sel(mult));
  usb_host_model usb_host_model_inst (.sys_clk(sys_clk), .en(host_en), .frame_len(flen), .sof(sof));
  // crystal tick every 4 cycles: 1024 per window, far out of range but short to run
  always @(posedge sys_clk) begin
    sdiv <= (sdiv == 8'd3) ? 8'h0 : sdiv + 8'h1;
    secondary_crystal_osc <= secondary_crystal_osc_en && sdiv == 8'd3;
    n_secondary_crystal_osc <= n_secondary_crystal_osc + int'(secondary_crystal_osc === 1'b1);
    n_sys <= n_sys + int'(sys_t === 1'b1);
    n_usb <= n_usb + int'(usb_t === 1'b1);
    n_ref <= n_ref + int'(ref_t === 1'b1);
  end
  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] got);
    logic [31:0] e, m;
    e = q_exp.pop_front();
    m = q_msk.pop_front();
    cmp_pin(got & m, e);
  endtask
  always @(posedge sys_clk) begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      cmp_rd(rsp.prdata);
    end
  end
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q_exp.push_back(e);
    q_msk.push_back(m);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic wait_sof(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      while (sof !== 1'b1) @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic clk_case(input int i);
    int s, u, f, n;
    n = i[2] ? 3 << i[1:0] : 1 << i[1:0];
    apb(8'h04, 1'b1, 32'(i[2]) << 20 | 32'(i[1:0]) << 16 | 32'(i) << 12 | 32'(i[1:0]) << 8 | 32'h3);
    repeat (4) @(posedge sys_clk);
    s = n_sys;
    u = n_usb;
    f = n_ref;
    // 120 cycles is a whole number of every divider period
    repeat (120) @(posedge sys_clk);
    cmp_pin(n_sys - s, 120 / n);
    cmp_pin(n_usb - u, 60);
    cmp_pin(n_ref - f, 120 / (i[2] ? dv[i] : 1));
    cmp_pin(mult, (i[2] || i[1:0] == 2'b11) ? 0 : i[1:0]);
    rd(8'h08, 32'(dv[i]) << 4 | 32'h2, 32'hf2);
  endtask
  task give_verdict();
    $display("counts: %0d compared, %0d mismatched", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(78768));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(8'h04, 32'h3, 32'h7);
    cmp_pin(from_pri, 1);
    for (int i = 0; i < 4; i++) begin
      apb(8'h04, 1'b1, {27'h0, src_cfg[i]});
      repeat (3) @(posedge sys_clk);
      cmp_pin(from_pri, src_exp[i]);
    end
    rd(8'h0c, 32'h0, 32'hffffffff);
    $display("test source select done");
    vco <= 1'b1;
    pin <= 1'b1;
    for (int i = 0; i < 8; i++) clk_case(i);
    $display("test clock tree done");
    r = 6'($urandom % 30);
    apb(8'h00, 1'b1, {26'h0, r});
    rd(8'h00, {26'h0, r}, 32'hff3f);
    fast_rc_osc <= 1'b1;
    host_en <= 1'b1;
    apb(8'h00, 1'b1, {26'h0, r} | 32'h9500);
    rd(8'h00, {26'h0, r} | 32'h9500, 32'hff3f);
    wait_sof(2);
    cmp_pin(trim, r + 6'h1);
    cmp_pin(irq, 1);
    rd(8'h00, {26'h0, r + 6'h1} | 32'h9f00, 32'hff3f);
    rd(8'h08, 32'h1, 32'h1);
    apb(8'h00, 1'b1, 32'h9000);
    repeat (3) @(posedge sys_clk);
    cmp_pin(irq, 0);
    cmp_pin(trim, r + 6'h1);
    flen <= 16'd9000;
    wait_sof(1);
    cmp_pin(trim, r);
    apb(8'h00, 1'b1, {26'h0, r});
    host_en <= 1'b0;
    rd(8'h00, {26'h0, r}, 32'hff3f);
    cmp_pin(irq, 0);
    $display("test usb reference done");
    apb(8'h00, 1'b1, {26'h0, r} | 32'h8500);
    secondary_crystal_osc_en <= 1'b1;
    while (n_secondary_crystal_osc < 512) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
    rd(8'h00, {26'h0, r + 6'h1} | 32'h8f00, 32'hff3f);
    cmp_pin(irq, 1);
    $display("test crystal reference done");
    give_verdict();
  end
endmodule // rc_self_tune_and_pll_clocking_tb_top
bind rc_self_tune_and_pll_clocking rc_tune_checker rc_tune_checker_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .usb_sof_pulse(usb_sof_pulse),
  .secondary_crystal_osc_tick(secondary_crystal_osc_tick), .pll_in_tick(pll_in_tick), .vco_tick(vco_tick), .rc_trim_field(rc_trim_field),
  .self_tune_irq_flag(self_tune_irq_flag), .pll_ref_tick(pll_ref_tick), .usb_clk_tick(usb_clk_tick),
  .sys_clk_tick(sys_clk_tick), .pll_mult_sel(pll_mult_sel));
`default_nettype wire
